// File: logic/pdsc_pin_control.sv
// power-down, self-test and gpio pin control with an AHB-Lite register slave
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module pdsc_pin_control (
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  input  wire logic                          powerdownBarInput,
  input  wire logic                          selftestEnablePin,
  input  wire logic                          clockSelectIntPin,
  input  wire logic [pdsc_pkg::NUM_GPIO-1:0] gpioIn,
  output logic      [pdsc_pkg::NUM_GPIO-1:0] gpioOut,
  output logic      [pdsc_pkg::NUM_GPIO-1:0] gpioOe_n,
  input  wire logic                          audioSerialOut,
  input  wire logic                          audioWordClock,
  input  wire logic                          audioDataLaneC,
  input  wire logic                          audioDataLaneD,
  output logic                               coreReset_n,
  output logic                               pllEnable,
  output logic                               selftestMode,
  output logic                               selftestClockSelect,
  output logic                               externalInterruptInput,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp
);

  //------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------
  logic [pdsc_pkg::SYNC_WIDTH-1:0] pinSync;
  logic                            pdbSync;
  logic                            stenSync;
  logic                            selSync;
  logic [pdsc_pkg::NUM_GPIO-1:0]   gpioSync;

  pdsc_sync #(
    .W(pdsc_pkg::SYNC_WIDTH)
  ) u_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .asyncIn ({gpioIn, clockSelectIntPin, selftestEnablePin, powerdownBarInput}),
    .syncOut (pinSync)
  );

  assign pdbSync  = pinSync[pdsc_pkg::SYNC_PDB];   // see (R9) (R3)
  assign stenSync = pinSync[pdsc_pkg::SYNC_STEN];
  assign selSync  = pinSync[pdsc_pkg::SYNC_SEL];
  assign gpioSync = pinSync[pdsc_pkg::SYNC_GPIO +: pdsc_pkg::NUM_GPIO];

  // internal logic held in reset while powered down
  logic coreRun;
  assign coreRun = reset_n && pdbSync;              // see (R9) (R1)

  //------------------------------------------------------------
  // AHB-Lite slave
  //------------------------------------------------------------
  function automatic pdsc_pkg::pdsc_reg_t regDecode(input logic [31:0] addr);
    if (addr == pdsc_pkg::ADDR_CTRL) begin
      return pdsc_pkg::REG_CTRL;
    end else if (addr == pdsc_pkg::ADDR_STATUS) begin
      return pdsc_pkg::REG_STATUS;
    end
    return pdsc_pkg::REG_NONE;
  endfunction

  pdsc_pkg::pdsc_ctrl_t   ctrl_q;
  pdsc_pkg::pdsc_status_t status;
  pdsc_pkg::pdsc_reg_t    wrReg_q;
  logic                   wrPend_q;
  logic                   access;
  logic [31:0]            readWord;

  assign access    = hsel && hready && (htrans == pdsc_pkg::HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp     = pdsc_pkg::HRESP_OKAY;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      wrReg_q  <= pdsc_pkg::REG_NONE;
    end else begin
      wrPend_q <= access && hwrite;
      wrReg_q  <= regDecode(haddr);
    end
  end

  // control register, cleared whenever the device is powered down
  always_ff @(posedge clock) begin
    if (!coreRun) begin
      ctrl_q <= pdsc_pkg::CTRL_RESET;                // see (R1) (R8)
    end else if (wrPend_q && wrReg_q == pdsc_pkg::REG_CTRL) begin
      ctrl_q <= pdsc_pkg::pdsc_ctrl_t'(hwdata[$bits(pdsc_pkg::pdsc_ctrl_t)-1:0]);
    end
  end

  always_comb begin
    status              = '0;
    status.enabled      = pdbSync;
    status.selftestMode = selftestMode;
    status.clkSel33     = selftestClockSelect;
    status.extInterrupt = externalInterruptInput;
    status.pinLevel     = gpioSync;
  end

  // forward a write in its data phase to a read that follows it
  always_comb begin
    case (regDecode(haddr))
      pdsc_pkg::REG_CTRL: begin
        if (wrPend_q && wrReg_q == pdsc_pkg::REG_CTRL && coreRun) begin
          readWord = {24'h00_0000, hwdata[$bits(pdsc_pkg::pdsc_ctrl_t)-1:0]};
        end else begin
          readWord = {24'h00_0000, ctrl_q};
        end
      end
      pdsc_pkg::REG_STATUS: readWord = {24'h00_0000, status};
      default:              readWord = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (access && !hwrite) begin
      hrdata <= readWord;
    end
  end

  //------------------------------------------------------------
  // power state, self-test and shared pin
  //------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      coreReset_n <= 1'b0;
      pllEnable   <= 1'b0;
    end else begin
      coreReset_n <= pdbSync;                        // see (R9)
      pllEnable   <= pdbSync;                        // see (R2)
    end
  end

  always_ff @(posedge clock) begin
    if (!coreRun) begin
      selftestMode           <= 1'b0;
      selftestClockSelect    <= pdsc_pkg::STCLK_PIXEL;
      externalInterruptInput <= 1'b0;
    end else begin
      selftestMode           <= stenSync;                              // see (R5)
      selftestClockSelect    <= stenSync ? selSync : pdsc_pkg::STCLK_PIXEL; // see (R6)
      externalInterruptInput <= !stenSync && selSync;                  // see (R7)
    end
  end

  //------------------------------------------------------------
  // gpio pins
  //------------------------------------------------------------
  logic [pdsc_pkg::NUM_GPIO-1:0] audioBus;
  pdsc_pkg::pdsc_gpio_t          gpio_q;

  assign audioBus = {audioDataLaneD, audioDataLaneC, audioWordClock, audioSerialOut};

  always_ff @(posedge clock) begin
    if (!coreRun) begin
      gpio_q.out <= '0;
      gpio_q.oeN <= '1;                              // see (R2)
    end else begin
      gpio_q.oeN <= '0;                              // see (R8)
      gpio_q.out <= (ctrl_q.altSel & audioBus) | (~ctrl_q.altSel & ctrl_q.level);
    end
  end

  assign gpioOut  = gpio_q.out;
  assign gpioOe_n = gpio_q.oeN;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  powerdown_outs_a: assert property (!pdbSync |=> (&gpioOe_n) && !pllEnable) // see (R2)
    else $error("outputs not released or clock generator on in power-down");

  undriven_low_a: assert property (disable iff (1'b0) !reset_n |=> !pdbSync) // see (R3)
    else $error("power-down input not low after reset");

  sync_delay_a: assert property ($past(reset_n) && $past(reset_n, 2) |-> // see (R9)
    pdbSync == $past(powerdownBarInput, 2))
    else $error("power-down input not seen two cycles later");

  hold_reset_a: assert property (!pdbSync |=> !coreReset_n && ctrl_q == '0) // see (R9)
    else $error("internal reset released while powered down");

  regs_default_a: assert property ($rose(pdbSync) |-> ctrl_q == '0 && !selftestMode) // see (R1)
    else $error("state not at default on power-up");

  selftest_mode_a: assert property (##1 selftestMode == $past(stenSync && pdbSync)) // see (R5)
    else $error("self-test mode does not follow enable pin");

  clk_select_a: assert property (selftestMode |=> // see (R6)
    selftestClockSelect == ($past(selSync) && $past(stenSync) && selftestMode))
    else $error("self-test clock select wrong");

  int_input_a: assert property (##1 externalInterruptInput == // see (R7)
    $past(pdbSync && !stenSync && selSync))
    else $error("interrupt input not passed outside self-test");

  gpio_default_a: assert property ($rose(pdbSync) |=> gpioOut == '0 && gpioOe_n == '0) // see (R8)
    else $error("gpio pins not driven low after power-up");

  powerup_c:   cover property ($rose(pdbSync) ##1 $rose(pllEnable));
  selftest_c:  cover property (selftestMode && selftestClockSelect == pdsc_pkg::STCLK_33MHZ);
  altfunc_c:   cover property (pdbSync && ctrl_q.altSel != '0);
  busWrite_c:  cover property (wrPend_q && wrReg_q == pdsc_pkg::REG_CTRL);

endmodule

// File: include/pdsc_pkg.sv
// constants and types of the power-down and self-test pin control block
// Functional notes
// (R1) raising power-down input returns everything to defaults
// (R2) power-down low: outputs released, clock generator off
// (R3) undriven power-down input reads low
// (R4) host holds power-down low until supplies settle
// (R5) self-test enable pin: 0 off, 1 on
// (R6) self-test clock select: 0 pixel, 1 33 MHz
// (R7) shared pin is interrupt input by default
// (R8) gpio pins drive low until alternate audio selected; code drives the ctrl level bits instead, 0 after power-up
// (R9) power-down input synchronised, holds internal reset
package pdsc_pkg;

  localparam int          NUM_GPIO      = 4;
  localparam int          SYNC_WIDTH    = 3 + NUM_GPIO;
  localparam int          SYNC_PDB      = 0;
  localparam int          SYNC_STEN     = 1;
  localparam int          SYNC_SEL      = 2;
  localparam int          SYNC_GPIO     = 3;

  localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_0004;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

  localparam logic        STCLK_PIXEL   = 1'h0;
  localparam logic        STCLK_33MHZ   = 1'h1;

  // control word: bits 3:0 pin levels, bits 7:4 audio function enables
  typedef struct packed {
    logic [NUM_GPIO-1:0] altSel;
    logic [NUM_GPIO-1:0] level;
  } pdsc_ctrl_t;

  // status word: bit 0 enabled, 1 self-test, 2 clk 33 MHz, 3 interrupt, 7:4 pins
  typedef struct packed {
    logic [NUM_GPIO-1:0] pinLevel;
    logic                extInterrupt;
    logic                clkSel33;
    logic                selftestMode;
    logic                enabled;
  } pdsc_status_t;

  typedef struct packed {
    logic [NUM_GPIO-1:0] out;
    logic [NUM_GPIO-1:0] oeN;
  } pdsc_gpio_t;

  localparam pdsc_ctrl_t  CTRL_RESET    = '0;

  typedef enum {
    REG_CTRL,
    REG_STATUS,
    REG_NONE
  } pdsc_reg_t;

endpackage

// File: logic/pdsc_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pdsc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_q;

  // reset to low so an undriven input reads as low
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

// File: sim/pdsc_host_gpio.sv
// host processor gpio model driving the power-down and self-test pins
`timescale 1ns/1ps
module pdsc_host_gpio (
  input  wire logic clock,
  input  wire logic supplyOk,
  input  wire logic enableReq,
  input  wire logic pdbDriven,
  input  wire logic selftestReq,
  input  wire logic clkSelReq,
  output logic      powerdownBarInput,
  output logic      selftestEnablePin,
  output logic      clockSelectIntPin
);
  logic pdbLevel_q = 1'b0;

  initial selftestEnablePin = 1'b0;
  initial clockSelectIntPin = 1'b0;
  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  always @(posedge clock) begin
    pdbLevel_q        <= enableReq & supplyOk;
    selftestEnablePin <= selftestReq;
    clockSelectIntPin <= clkSelReq;
  end
  // weak pulldown: released pin reads low
  assign powerdownBarInput = pdbDriven ? pdbLevel_q : 1'b0;
endmodule

// File: sim/powerdown_selftest_pin_control_tb.sv
// self-checking bench of the power-down and self-test pin control block
`timescale 1ns/1ps
module powerdown_selftest_pin_control_tb;
  logic        clock = 1'b0;
  logic        reset_n, supplyOk, enableReq, pdbDriven, selftestReq, clkSelReq;
  logic        pdbPin, stPin, csPin, hsel, hwrite, hreadyout, hresp;
  logic        coreReset_n, pllEnable, selftestMode, selftestClockSelect, externalInterruptInput;
  logic [3:0]  audio, gpioIn, gpioOut, gpioOe_n;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          bad_count = 0;
  int          cmp_count = 0;

  always #25 clock = ~clock;
  // pins released by the block fall to their pulldown
  for (genvar i = 0; i < 4; i++) begin : g_pin
    assign gpioIn[i] = gpioOe_n[i] ? 1'b0 : gpioOut[i];
  end

  pdsc_host_gpio host (.clock(clock), .supplyOk(supplyOk), .enableReq(enableReq),
    .pdbDriven(pdbDriven), .selftestReq(selftestReq), .clkSelReq(clkSelReq),
    .powerdownBarInput(pdbPin), .selftestEnablePin(stPin), .clockSelectIntPin(csPin));

  pdsc_pin_control dut (.clock(clock), .reset_n(reset_n), .powerdownBarInput(pdbPin),
    .selftestEnablePin(stPin), .clockSelectIntPin(csPin), .gpioIn(gpioIn),
    .gpioOut(gpioOut), .gpioOe_n(gpioOe_n), .audioSerialOut(audio[0]),
    .audioWordClock(audio[1]), .audioDataLaneC(audio[2]), .audioDataLaneD(audio[3]),
    .coreReset_n(coreReset_n), .pllEnable(pllEnable), .selftestMode(selftestMode),
    .selftestClockSelect(selftestClockSelect),
    .externalInterruptInput(externalInterruptInput), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= pdsc_pkg::HTRANS_NONSEQ;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic pins(input logic en, input logic st, input logic cs);
    @(posedge clock);
    enableReq   <= en;
    selftestReq <= st;
    clkSelReq   <= cs;
    repeat (6) @(posedge clock);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_undriven;
    pins(1'b1, 1'b0, 1'b0);
    chk({30'h0, coreReset_n, pllEnable}, 32'h0);
    chk({28'h0, gpioOe_n}, 32'hf);
  endtask

  task automatic t_enable;
    pdbDriven <= 1'b1;
    pins(1'b1, 1'b0, 1'b0);
    chk({30'h0, coreReset_n, pllEnable}, 32'h3);
    chk({24'h0, gpioOe_n, gpioOut}, 32'h0);
  endtask

  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      pins(1'b1, m[1], m[0]);
      chk({31'h0, selftestMode}, {31'h0, m[1]});
      chk({31'h0, selftestClockSelect}, {31'h0, m[1] & m[0]});
      chk({31'h0, externalInterruptInput}, {31'h0, !m[1] & m[0]});
      ahb(1'b0, pdsc_pkg::ADDR_STATUS, 32'h0);
      chk(rd, {28'h0, !m[1] & m[0], m[1] & m[0], m[1], 1'b1});
    end
  endtask

  task automatic t_gpio;
    pins(1'b1, 1'b0, 1'b0);
    ahb(1'b1, pdsc_pkg::ADDR_CTRL, 32'h05);
    repeat (4) @(posedge clock);
    chk({28'h0, gpioOut}, 32'h5);
    ahb(1'b0, pdsc_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h51);
    ahb(1'b1, pdsc_pkg::ADDR_CTRL, 32'hf0);
    for (int v = 10; v > 0; v -= 5) begin
      audio <= v[3:0];
      repeat (4) @(posedge clock);
      chk({28'h0, gpioOut}, v);
    end
    ahb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_powerdown;
    pins(1'b0, 1'b1, 1'b1);
    chk({29'h0, coreReset_n, pllEnable, selftestMode}, 32'h0);
    chk({28'h0, gpioOe_n}, 32'hf);
    ahb(1'b1, pdsc_pkg::ADDR_CTRL, 32'h0f);
    pins(1'b1, 1'b0, 1'b0);
    ahb(1'b0, pdsc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    chk({28'h0, gpioOut}, 32'h0);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {reset_n, supplyOk, enableReq, pdbDriven, selftestReq, clkSelReq} = '0;
    {hsel, hwrite, htrans, audio, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge clock);
    reset_n  <= 1'b1;
    supplyOk <= 1'b1;
    t_undriven;
    t_enable;
    t_modes;
    t_gpio;
    t_powerdown;
    wrap_up;
  end

  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    wrap_up;
  end
endmodule
